// [hw/blia_regs.svh]
// offsets, field positions, reset values and timing counts of the interrupt aggregator
`ifndef BLIA_REGS_SVH
`define BLIA_REGS_SVH

// register offsets on the software port
`define BLIA_ADDR_STATUS 4'h0
`define BLIA_ADDR_ENABLE 4'h1
`define BLIA_ADDR_CLEAR 4'h2
`define BLIA_ADDR_PERIOD 4'h3
`define BLIA_ADDR_CMD 4'h4
`define BLIA_ADDR_CTL_STATUS 4'h8
`define BLIA_ADDR_CTL_MASK 4'h9

// source bit positions, shared by status, enable and clear
`define BLIA_BIT_ONE_SECOND 0
`define BLIA_BIT_TIMING 1
`define BLIA_BIT_CMD_DONE 2

// controller status bit positions
`define BLIA_CBIT_LINE_RISE 0
`define BLIA_CBIT_LOW_LINE 1

// reset values
`define BLIA_ENABLE_RESET 3'h0
`define BLIA_PERIOD_RESET 16'h03e8

// timing
`define BLIA_SYS_CLOCK_HZ 24000000
`define BLIA_IFACE_CLOCK_HZ 1000000
`define BLIA_IFACE_DIV (`BLIA_SYS_CLOCK_HZ / `BLIA_IFACE_CLOCK_HZ)
`define BLIA_ONE_SECOND_S 1
`define BLIA_ONE_SECOND_TICKS (`BLIA_ONE_SECOND_S * `BLIA_IFACE_CLOCK_HZ)

`endif

// [hw/blia_pkg.sv]
// types shared by both ends of the interrupt aggregator link
package blia_pkg;
    typedef logic [2:0] blia_src_t;
    typedef logic [3:0] blia_addr_t;
    typedef logic [15:0] blia_data_t;
endpackage

// [hw/blia_link_if.sv]
// link between the board logic and the processor side
`timescale 1ns/10ps
interface blia_link_if;
    import blia_pkg::*;
    logic high_priority_irq_line;
    logic low_priority_irq_line;
    blia_addr_t addr;
    blia_data_t wdata;
    logic wr;
    logic rd;
    blia_data_t rdata;

    modport device (
        output high_priority_irq_line,
        input low_priority_irq_line,
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata
    );
    modport host (
        input high_priority_irq_line,
        output low_priority_irq_line,
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata
    );
endinterface

// [hw/blia_device.sv]
// board logic interrupt aggregator: latches, enables, tick generation
// What this block and the processor software must do
// - line is OR of enabled latched sources
// - latch one-second tick until cleared
// - latch timing tick until cleared
// - latch command DMA completion until cleared
// - separate enables, all disabled at reset
// - latched flags readable regardless of enables
// - aggregate uses the high-priority line
// - processor masks all on service entry
// - processor restores enables on service exit
// - re-enable of set latch gives new edge
// - processor disables timing irq before period change
// - processor clears timing latch before re-enable
// - ticks derive from 1 MHz interface clock
`timescale 1ns/10ps
`include "blia_regs.svh"
module blia_device
    import blia_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_dma_done,
    blia_link_if.device link
);

    ////////////////////////////////////////////////////////////////////////
    logic [4:0] iface_div_q;
    logic iface_en;
    logic [19:0] second_cnt_q;
    logic [15:0] timing_cnt_q;
    blia_data_t period_q;
    logic one_second_tick;
    logic timing_tick;
    blia_src_t enable_q;
    blia_src_t latch_q;
    blia_src_t event_in;
    blia_src_t clear_strobe;
    blia_data_t rdata_q;

    // 24 MHz system clock divided to a 1 MHz interface enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            iface_div_q <= 5'h0;
        end else if (iface_div_q == 5'(`BLIA_IFACE_DIV - 1)) begin
            iface_div_q <= 5'h0;
        end else begin
            iface_div_q <= iface_div_q + 5'h1;
        end
    end
    assign iface_en = (iface_div_q == 5'(`BLIA_IFACE_DIV - 1));

    // free running count of interface cycles; tick at its maximum
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            second_cnt_q <= 20'h0_0000;
        end else if (iface_en) begin
            if (second_cnt_q == 20'(`BLIA_ONE_SECOND_TICKS - 1)) begin
                second_cnt_q <= 20'h0_0000;
            end else begin
                second_cnt_q <= second_cnt_q + 20'h0_0001;
            end
        end
    end
    assign one_second_tick = iface_en &&
        (second_cnt_q == 20'(`BLIA_ONE_SECOND_TICKS - 1));

    // programmable timing tick, period in interface cycles
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timing_cnt_q <= 16'h0000;
        end else if (iface_en) begin
            if (timing_cnt_q >= period_q - 16'h0001) begin
                timing_cnt_q <= 16'h0000;
            end else begin
                timing_cnt_q <= timing_cnt_q + 16'h0001;
            end
        end
    end
    // a period of zero stops the tick rather than firing every 65536 interface cycles
    assign timing_tick = iface_en && (period_q != 16'h0000) &&
        (timing_cnt_q >= period_q - 16'h0001);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            period_q <= `BLIA_PERIOD_RESET;
        end else if (link.wr && link.addr == `BLIA_ADDR_PERIOD) begin
            period_q <= link.wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enable_q <= `BLIA_ENABLE_RESET;
        end else if (link.wr && link.addr == `BLIA_ADDR_ENABLE) begin
            enable_q <= link.wdata[2:0];
        end
    end

    assign clear_strobe = (link.wr && link.addr == `BLIA_ADDR_CLEAR) ?
        link.wdata[2:0] : 3'h0;

    always_comb begin
        event_in = 3'h0;
        event_in[`BLIA_BIT_ONE_SECOND] = one_second_tick;
        event_in[`BLIA_BIT_TIMING] = timing_tick;
        event_in[`BLIA_BIT_CMD_DONE] = cmd_dma_done;
    end

    // set wins over a clear in the same cycle
    for (genvar i = 0; i < 3; i++) begin : g_latch
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                latch_q[i] <= 1'b0;
            end else if (event_in[i]) begin
                latch_q[i] <= 1'b1;
            end else if (clear_strobe[i]) begin
                latch_q[i] <= 1'b0;
            end
        end
    end

    // combinational OR: an enable step on a set latch shows as an edge
    assign link.high_priority_irq_line = |(latch_q & enable_q);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (link.rd) begin
            unique case (link.addr)
                `BLIA_ADDR_STATUS: rdata_q <= {13'h0000, latch_q};
                `BLIA_ADDR_ENABLE: rdata_q <= {13'h0000, enable_q};
                `BLIA_ADDR_PERIOD: rdata_q <= period_q;
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign link.rdata = rdata_q;

endmodule

// [hw/blia_host.sv]
// processor-side end: software port, controller status and mask, pulse clears
`timescale 1ns/10ps
`include "blia_regs.svh"
module blia_host
    import blia_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic low_irq_in,
    input wire logic [3:0] sw_addr,
    input wire logic [15:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [15:0] sw_rdata,
    output logic irq,
    blia_link_if.host link
);

    ////////////////////////////////////////////////////////////////////////
    logic line_q;
    logic [1:0] ctl_status_q;
    logic [1:0] ctl_mask_q;
    logic [1:0] ctl_event;
    logic local_sel;
    blia_data_t sw_rdata_q;

    assign local_sel = (sw_addr == `BLIA_ADDR_CTL_STATUS) || (sw_addr == `BLIA_ADDR_CTL_MASK);

    // software reaches the device registers directly; service-entry masking,
    // restore and timing clears are software's order of writes
    assign link.addr = sw_addr;
    assign link.wdata = sw_wdata;
    assign link.wr = sw_wr && !local_sel;
    assign link.rd = sw_rd && !local_sel;
    assign link.low_priority_irq_line = low_irq_in;

    // processor sees only edges of the high-priority line, so detect its rise
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_q <= 1'b0;
        end else begin
            line_q <= link.high_priority_irq_line;
        end
    end

    always_comb begin
        ctl_event = 2'h0;
        ctl_event[`BLIA_CBIT_LINE_RISE] = link.high_priority_irq_line && !line_q;
        ctl_event[`BLIA_CBIT_LOW_LINE] = low_irq_in;
    end

    for (genvar i = 0; i < 2; i++) begin : g_ctl
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                ctl_status_q[i] <= 1'b0;
            end else if (ctl_event[i]) begin
                ctl_status_q[i] <= 1'b1;
            end else if (sw_wr && sw_addr == `BLIA_ADDR_CTL_STATUS && sw_wdata[i]) begin
                ctl_status_q[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl_mask_q <= 2'h0;
        end else if (sw_wr && sw_addr == `BLIA_ADDR_CTL_MASK) begin
            ctl_mask_q <= sw_wdata[1:0];
        end
    end

    assign irq = |(ctl_status_q & ctl_mask_q);

    // local reads answered here; device reads pass its registered data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sw_rdata_q <= 16'h0000;
        end else if (sw_rd && sw_addr == `BLIA_ADDR_CTL_STATUS) begin
            sw_rdata_q <= {14'h0000, ctl_status_q};
        end else if (sw_rd && sw_addr == `BLIA_ADDR_CTL_MASK) begin
            sw_rdata_q <= {14'h0000, ctl_mask_q};
        end else begin
            sw_rdata_q <= 16'h0000;
        end
    end
    assign sw_rdata = sw_rdata_q | link.rdata;

endmodule

// [tb/blia_asserts.sv]
// concurrent checks on the aggregator link
`timescale 1ns/10ps
module blia_asserts
    import blia_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic high_priority_irq_line,
    input wire blia_addr_t addr,
    input wire blia_data_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire blia_data_t rdata
);
    logic [2:0] en_q;
    logic [2:0] seen_q;
    logic st_rd_q;
    wire logic hp = high_priority_irq_line;
    wire logic en_wr = wr && addr == 4'h1;
    wire logic clr_wr = wr && addr == 4'h2;
    wire logic st_rd = rd && addr == 4'h0;
    //////////////////////////////////////////////////
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en_q <= 3'h0;
        end else if (en_wr) begin
            en_q <= wdata[2:0];
        end
    end
    // lower bound of the latches: an event may set more, never fewer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seen_q <= 3'h0;
            st_rd_q <= 1'b0;
        end else begin
            st_rd_q <= st_rd;
            seen_q <= (seen_q | (st_rd_q ? rdata[2:0] : 3'h0)) & ~(clr_wr ? wdata[2:0] : 3'h0);
        end
    end
    //////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    rdata_idle_zero_a: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data not idle");
    line_needs_enable_a: assert property (hp |-> en_q != 3'h0)
        else $error("line high with no enable");
    mask_drops_line_a: assert property (en_wr && wdata[2:0] == 3'h0 |=> !hp)
        else $error("line high after mask");
    enable_readback_a: assert property (rd && addr == 4'h1 |=> rdata[2:0] == $past(en_q))
        else $error("enable readback wrong");
    status_vs_line_a: assert property (st_rd |=> ((rdata[2:0] & $past(en_q)) != 3'h0) == $past(hp))
        else $error("line disagrees with status");
    line_sticky_a: assert property (hp && !en_wr && !clr_wr |=> hp)
        else $error("line dropped on its own");
    reenable_edge_a: assert property (en_wr && (wdata[2:0] & seen_q) != 3'h0 |=> hp)
        else $error("no line on re-enable");
    status_sticky_a: assert property (st_rd |=> (rdata[2:0] & $past(seen_q)) == $past(seen_q))
        else $error("latch lost");
endmodule

// [tb/tb.sv]
// self-checking bench for the aggregator pair
`timescale 1ns/10ps
`include "blia_regs.svh"
module tb;
    import blia_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cmd_dma_done = 1'b0;
    logic low_irq_in = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [15:0] sw_wdata = 16'h0000;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [15:0] sw_rdata;
    logic irq;
    int n_fail = 0;
    int samples_checked = 0;
    blia_link_if link();
    blia_device i_blia_device (.clock(clock), .rst(rst), .cmd_dma_done(cmd_dma_done),
        .link(link.device));
    blia_host i_blia_host (.clock(clock), .rst(rst), .low_irq_in(low_irq_in), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq),
        .link(link.host));
    blia_asserts u_chk (.clock(clock), .rst(rst), .high_priority_irq_line(link.high_priority_irq_line),
        .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
    //////////////////////////////////////////////////
    initial begin
        forever #12.5 clock = ~clock;
    end
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // ev raises the completion pulse in the very cycle of the write
    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic ev);
        @(posedge clock);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        cmd_dma_done <= ev;
        @(posedge clock);
        sw_wr <= 1'b0;
        cmd_dma_done <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
        @(posedge clock);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clock);
        sw_rd <= 1'b0;
        #1;
        chk(name, sw_rdata, exp);
    endtask
    // two edges: the controller status may register the line rise first
    task automatic pins(input logic [1:0] exp);
        repeat (2) @(posedge clock);
        #1;
        chk("irq,line", {14'h0000, irq, link.high_priority_irq_line}, {14'h0000, exp});
    endtask
    //////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(`BLIA_ADDR_STATUS, 16'h0000, "status");
        rd(`BLIA_ADDR_ENABLE, {13'h0000, `BLIA_ENABLE_RESET}, "enable");
        rd(`BLIA_ADDR_PERIOD, `BLIA_PERIOD_RESET, "period");
        rd(4'h7, 16'h0000, "unmapped");
        $display("reset test done");
        wr(4'h7, 16'hffff, 1'b1);
        rd(`BLIA_ADDR_STATUS, 16'h0004, "status");
        pins(2'b00);
        wr(`BLIA_ADDR_CTL_MASK, 16'h0001, 1'b0);
        wr(`BLIA_ADDR_ENABLE, 16'h0004, 1'b0);
        pins(2'b11);
        rd(`BLIA_ADDR_CTL_STATUS, 16'h0001, "ctl status");
        wr(`BLIA_ADDR_CTL_STATUS, 16'h0001, 1'b0);
        wr(`BLIA_ADDR_ENABLE, 16'h0000, 1'b0);
        pins(2'b00);
        wr(`BLIA_ADDR_ENABLE, 16'h0007, 1'b0);
        pins(2'b11);
        wr(`BLIA_ADDR_CLEAR, 16'h0003, 1'b0);
        rd(`BLIA_ADDR_STATUS, 16'h0004, "status");
        wr(`BLIA_ADDR_CTL_STATUS, 16'h0001, 1'b0);
        wr(`BLIA_ADDR_CLEAR, 16'h0004, 1'b0);
        pins(2'b00);
        $display("completion test done");
        wr(`BLIA_ADDR_CLEAR, 16'h0004, 1'b1);
        rd(`BLIA_ADDR_STATUS, 16'h0004, "status");
        wr(`BLIA_ADDR_ENABLE, 16'h0000, 1'b0);
        wr(`BLIA_ADDR_CLEAR, 16'h0004, 1'b0);
        // the race left a fresh line rise in the controller status
        wr(`BLIA_ADDR_CTL_STATUS, 16'h0001, 1'b0);
        $display("clear race test done");
        wr(`BLIA_ADDR_PERIOD, 16'h0002, 1'b0);
        rd(`BLIA_ADDR_PERIOD, 16'h0002, "period");
        repeat (4 * `BLIA_IFACE_DIV + 4) @(posedge clock);
        wr(`BLIA_ADDR_PERIOD, 16'h0000, 1'b0);
        rd(`BLIA_ADDR_STATUS, 16'h0002, "status");
        wr(`BLIA_ADDR_CLEAR, 16'h0002, 1'b0);
        wr(`BLIA_ADDR_ENABLE, 16'h0002, 1'b0);
        pins(2'b00);
        $display("timing tick test done");
        @(posedge clock);
        low_irq_in <= 1'b1;
        pins(2'b00);
        rd(`BLIA_ADDR_CTL_STATUS, 16'h0002, "ctl status");
        wr(`BLIA_ADDR_CTL_MASK, 16'h0002, 1'b0);
        pins(2'b10);
        @(posedge clock);
        low_irq_in <= 1'b0;
        wr(`BLIA_ADDR_CTL_STATUS, 16'h0002, 1'b0);
        pins(2'b00);
        $display("controller test done");
        end_sim();
    end
endmodule
